// File: test/sfb_host.sv
`timescale 1ns/10ps
module sfb_host
    import sfb_pkg::*;
(
    output logic spi_clk,
    output logic cs_n,
    output sfb_lanes_s host_out,
    output sfb_lanes_s host_oe,
    input sfb_lanes_s lanes_in
);
    logic cpol;
    logic hold_n;
    // Select starts low so that only a later falling edge may select
    initial begin
        cpol = 1'b0;
        hold_n = 1'b1;
        spi_clk = 1'b0;
        cs_n = 1'b0;
        host_out = 4'hF;
        host_oe = 4'h8;
    end
    // ********************************
    // Frame tasks
    // ********************************
    // clock idles at mode level
    task automatic begin_frame(input logic mode3);
        cpol = mode3;
        spi_clk = mode3;
        #65.5;
        cs_n = 1'b0;
        #62.5;
    endtask
    task automatic shift(input int w, input int n, input logic drv, input logic [31:0] v, output logic [31:0] r);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        r = '0;
        for (int k = n - 1; k >= 0; k--) begin
            spi_clk = 1'b0;
            host_oe = drv ? (m | 4'h8) : (w == 4 ? 4'h0 : 4'h8);
            host_out = 4'((v >> (w * k)) & 32'(m));
            if (w < 4) host_out.lane_three = hold_n;
            #62.5;
            spi_clk = 1'b1;
            r = (r << w) | (w == 1 ? 32'(lanes_in.lane_one) : 32'(lanes_in & m));
            #62.5;
        end
    endtask
    task automatic end_frame();
        #62.5;
        spi_clk = cpol;
        host_oe = 4'h8;
        host_out = {hold_n, 3'b111};
        #62.5;
        cs_n = 1'b1;
        // Gap lets select cross into the system clock; odd length keeps edges off the clock grid
        #497;
    endtask
    task automatic set_hold(input logic v);
        hold_n = v;
        host_out.lane_three = v;
    endtask
    task automatic park(input logic v);
        spi_clk = v;
    endtask
endmodule

// File: test/test_sfb_frontend.sv
`timescale 1ns/10ps
`include "sfb_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_sfb_frontend
    import sfb_pkg::*;
;
    localparam int RST_N = 200;
    logic clock, sys_rst, quad_enable_bit, hold_rst_sel, busy_in, supply_low, spi_clk, cs_n;
    logic reset_active, sw_reset, standby, paused, oe_desel = 1'b0;
    sfb_lanes_s dut_out, dut_oe, host_out, host_oe;
    wire sfb_lanes_s lanes;
    logic [7:0] rd_byte;
    logic [`SFB_ADDR_W-1:0] rd_addr;
    sfb_region_s rd_region;
    logic [3:0] oe_acc = 4'h0;
    int bad_count = 0, n_tests = 0, pulses = 0, act_cycles = 0, cycles = 0;
    // ********************************
    // Wiring, monitor and closing
    // ********************************
    // Released lanes zero and one toggle so a stale value never passes; two and three have pull-ups
    for (genvar i = 0; i < 4; i++) begin : g_wire
        assign lanes[i] = dut_oe[i] ? dut_out[i] : host_oe[i] ? host_out[i] : (i > 1 ? 1'b1 : ~spi_clk);
    end
    assign rd_byte = rd_addr[7:0] ^ 8'h5A;
    sfb_frontend #(.RST_CYCLES(RST_N)) sfb_frontend_inst (.clock(clock), .sys_rst(sys_rst), .spi_clk(spi_clk),
        .cs_n(cs_n), .lanes_in(lanes), .lanes_out(dut_out), .lanes_oe(dut_oe), .quad_enable_bit(quad_enable_bit),
        .hold_rst_sel(hold_rst_sel), .busy_in(busy_in), .supply_low(supply_low), .rd_byte(rd_byte),
        .rd_addr(rd_addr), .rd_region(rd_region), .reset_active(reset_active), .sw_reset(sw_reset),
        .standby(standby), .paused(paused));
    sfb_host sfb_host_inst (.spi_clk(spi_clk), .cs_n(cs_n), .host_out(host_out), .host_oe(host_oe), .lanes_in(lanes));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        pulses += int'(sw_reset === 1'b1);
        act_cycles += int'(reset_active === 1'b1);
        oe_acc = oe_acc | dut_oe;
        if (cs_n === 1'b1 && dut_oe !== 4'h0) oe_desel = 1'b1;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic results();
        $display("Summary: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic read(input logic [7:0] op, input int aw, input int dm, input int dw, input logic [23:0] a,
                        input logic mode3, input logic live);
        logic [31:0] r;
        oe_acc = 4'h0;
        sfb_host_inst.begin_frame(mode3);
        sfb_host_inst.shift(1, 8, 1'b1, {24'h0, op}, r);
        sfb_host_inst.shift(aw, 24 / aw, 1'b1, {8'h0, a}, r);
        if (dm > 0) sfb_host_inst.shift(aw, dm, 1'b1, 32'h0, r);
        sfb_host_inst.shift(dw, 8 / dw, 1'b0, 32'h0, r);
        if (live) begin
            `CHK(r[7:0], a[7:0] ^ 8'h5A)
            `CHK(rd_region, {a[17:12], a[17:15], a[17:16]})
            `CHK(rd_addr[23:18], 6'h00)
        end
        `CHK(oe_acc, live ? (dw == 1 ? 4'h2 : dw == 2 ? 4'h3 : 4'hF) : 4'h0)
        sfb_host_inst.end_frame();
    endtask
    task automatic op_frame(input logic [7:0] op, input int n);
        logic [31:0] r;
        sfb_host_inst.begin_frame(1'b0);
        sfb_host_inst.shift(1, n, 1'b1, {24'h0, op} >> (8 - n), r);
        sfb_host_inst.end_frame();
    endtask
    task automatic sw_seq(input int exp, input logic [7:0] mid, input logic part);
        int p0;
        p0 = pulses;
        if (part) op_frame(8'h99, 4);
        op_frame(8'h66, 8);
        if (mid != 8'h00) op_frame(mid, 8);
        op_frame(8'h99, 8);
        repeat (10) @(posedge clock);
        `CHK(pulses - p0, exp)
    endtask
    task automatic t_reads();
        @(posedge clock) quad_enable_bit <= 1'b1;
        read(8'h03, 1, 0, 1, 24'h03F0A5, 1'b0, 1'b1);
        read(8'h03, 1, 0, 1, 24'hFC1033, 1'b1, 1'b1);
        read(8'h0B, 1, 8, 1, 24'h017E01, 1'b0, 1'b1);
        read(8'h3B, 1, 8, 2, 24'h008C3C, 1'b0, 1'b1);
        read(8'hBB, 2, 4, 2, 24'h02F7F0, 1'b0, 1'b1);
        read(8'h6B, 1, 8, 4, 24'h038001, 1'b0, 1'b1);
        read(8'hEB, 4, 6, 4, 24'h030010, 1'b1, 1'b1);
        @(posedge clock) quad_enable_bit <= 1'b0;
        read(8'hEB, 4, 6, 4, 24'h030010, 1'b0, 1'b0);
        $display("test reads done");
    endtask
    task automatic t_pause();
        logic [31:0] r;
        sfb_host_inst.begin_frame(1'b0);
        sfb_host_inst.shift(1, 8, 1'b1, 32'h3, r);
        sfb_host_inst.shift(1, 24, 1'b1, 32'h10, r);
        sfb_host_inst.shift(1, 2, 1'b0, 32'h0, r);
        sfb_host_inst.set_hold(1'b0);
        repeat (10) @(posedge clock);
        `CHK(paused, 1'b0)
        `CHK(dut_oe.lane_one, 1'b1)
        sfb_host_inst.park(1'b0);
        repeat (10) @(posedge clock);
        `CHK(paused, 1'b1)
        `CHK(dut_oe, 4'h0)
        sfb_host_inst.set_hold(1'b1);
        repeat (10) @(posedge clock);
        `CHK(paused, 1'b0)
        sfb_host_inst.set_hold(1'b0);
        repeat (10) @(posedge clock);
        `CHK(paused, 1'b1)
        sfb_host_inst.end_frame();
        `CHK(paused, 1'b0)
        sfb_host_inst.set_hold(1'b1);
        $display("test pause done");
    endtask
    task automatic t_standby();
        @(posedge clock) busy_in <= 1'b1;
        repeat (6) @(posedge clock);
        `CHK(standby, 1'b0)
        @(posedge clock) busy_in <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK(standby, 1'b1)
        $display("test standby done");
    endtask
    task automatic t_resets();
        int a0;
        a0 = act_cycles;
        sw_seq(1, 8'h00, 1'b1);
        read(8'h03, 1, 0, 1, 24'h000100, 1'b0, 1'b0);
        for (int i = 0; i < 400 && reset_active !== 1'b0; i++) @(posedge clock);
        `CHK(act_cycles - a0, RST_N)
        sw_seq(0, 8'h05, 1'b0);
        @(posedge clock) supply_low <= 1'b1;
        sw_seq(0, 8'h00, 1'b0);
        @(posedge clock) supply_low <= 1'b0;
        @(posedge clock) hold_rst_sel <= 1'b1;
        sfb_host_inst.set_hold(1'b0);
        sw_seq(0, 8'h00, 1'b0);
        sfb_host_inst.set_hold(1'b1);
        @(posedge clock) hold_rst_sel <= 1'b0;
        sw_seq(1, 8'h00, 1'b0);
        for (int i = 0; i < 400 && reset_active !== 1'b0; i++) @(posedge clock);
        $display("test resets done");
    endtask
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        quad_enable_bit = 1'b0;
        hold_rst_sel = 1'b0;
        busy_in = 1'b0;
        supply_low = 1'b0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        sw_seq(0, 8'h00, 1'b0);
        $display("test first select done");
        t_reads();
        t_pause();
        t_standby();
        t_resets();
        `CHK(oe_desel, 1'b0)
        results();
    end
endmodule

// File: verilog/sfb_consts.svh
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH

// Address map
`define SFB_ADDR_W 24
`define SFB_ARRAY_MSB 17
`define SFB_TOP_ADDR 24'h03FFFF
`define SFB_SECT_LSB 12
`define SFB_HALF_LSB 15
`define SFB_BLK_LSB 16

// Instruction codes
`define SFB_OP_READ 8'h03
`define SFB_OP_FAST 8'h0B
`define SFB_OP_DUAL_OUT 8'h3B
`define SFB_OP_DUAL_IO 8'hBB
`define SFB_OP_QUAD_OUT 8'h6B
`define SFB_OP_QUAD_IO 8'hEB
`define SFB_OP_RST_EN 8'h66
`define SFB_OP_RST 8'h99

// Clocks spent after the address: mode bits plus dummy
`define SFB_DUMMY_FAST 5'h08
`define SFB_DUMMY_DUAL_IO 5'h04
`define SFB_DUMMY_QUAD_IO 5'h06

// Timing
`define SFB_CLK_MHZ 25
`define SFB_RST_TIME_US 300
`define SFB_RST_CYCLES (`SFB_RST_TIME_US * `SFB_CLK_MHZ)
`define SFB_RST_CNT_W 13

`endif

// File: verilog/sfb_frontend.sv
`timescale 1ns/10ps
`include "sfb_consts.svh"
module sfb_frontend
    import sfb_pkg::*;
#(
    parameter int unsigned RST_CYCLES = `SFB_RST_CYCLES
) (
    input logic clock,
    input logic sys_rst,
    input logic spi_clk,
    input logic cs_n,
    input sfb_lanes_s lanes_in,
    output sfb_lanes_s lanes_out,
    output sfb_lanes_s lanes_oe,
    input logic quad_enable_bit,
    input logic hold_rst_sel,
    input logic busy_in,
    input logic supply_low,
    input logic [7:0] rd_byte,
    output logic [`SFB_ADDR_W-1:0] rd_addr,
    output sfb_region_s rd_region,
    output logic reset_active,
    output logic sw_reset,
    output logic standby,
    output logic paused
);

    // ****************************************
    // Address decoding
    // ****************************************
    // sector, half and block indices
    function automatic sfb_region_s region_of(input logic [`SFB_ADDR_W-1:0] a);
        sfb_region_s r;
        r.sector = a[`SFB_ARRAY_MSB:`SFB_SECT_LSB];
        r.half = a[`SFB_ARRAY_MSB:`SFB_HALF_LSB];
        r.block = a[`SFB_ARRAY_MSB:`SFB_BLK_LSB];
        return r;
    endfunction

    function automatic logic [3:0] take_bits(input sfb_lanes_s l, input logic [2:0] w);
        logic [3:0] b;
        b = 4'h0;
        if (w == 3'h4) begin
            b = l;
        end else if (w == 3'h2) begin
            b = {2'h0, l.lane_one, l.lane_zero};
        end else begin
            b = {3'h0, l.lane_zero};
        end
        return b;
    endfunction

    function automatic logic is_quad(input logic [7:0] op);
        return (op == `SFB_OP_QUAD_OUT) || (op == `SFB_OP_QUAD_IO);
    endfunction

    // ****************************************
    // System-side pin synchronisers
    // ****************************************
    logic [3:0] pin_async;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    assign pin_async = {supply_low, lanes_in.lane_three, spi_clk, cs_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clock or posedge sys_rst) begin
                // Select resets low: reset alone must never count as the high that arms selection
                if (sys_rst) begin
                    pin_meta[gi] <= 1'(gi != 0);
                    pin_sync[gi] <= 1'(gi != 0);
                end else begin
                    pin_meta[gi] <= pin_async[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    wire cs_s = pin_sync[0];
    wire sclk_s = pin_sync[1];
    wire hold_s = pin_sync[2];
    wire low_s = pin_sync[3];

    // ****************************************
    // Select qualification, pause, hardware reset
    // ****************************************
    logic sel_armed;
    logic rst_busy;
    wire pause_en = ~quad_enable_bit & ~hold_rst_sel;
    wire hw_rst = hold_rst_sel & ~quad_enable_bit & ~hold_s;
    wire quiet = ~sel_armed | rst_busy | hw_rst | low_s;
    wire link_rst = sys_rst | quiet | cs_n;

    // need a high before select counts
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sel_armed <= 1'b0;
        end else if (low_s) begin
            sel_armed <= 1'b0;
        end else if (cs_s) begin
            sel_armed <= 1'b1;
        end
    end

    wire next_paused = (cs_s | ~pause_en) ? 1'b0 : (sclk_s ? paused : ~hold_s);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            paused <= 1'b0;
        end else begin
            paused <= next_paused;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            standby <= 1'b0;
        end else begin
            standby <= cs_s & ~busy_in;
        end
    end

    // ****************************************
    // Instruction event crossing and software reset
    // ****************************************
    logic op_tgl;
    logic [7:0] op_word;
    logic [2:0] tgl_s;
    logic reset_armed;
    logic [`SFB_RST_CNT_W-1:0] rst_cnt;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_s <= 3'h0;
        end else begin
            tgl_s <= {tgl_s[1:0], op_tgl};
        end
    end

    // Word is held stable by the link side well before its toggle arrives
    wire op_seen = tgl_s[2] ^ tgl_s[1];
    wire rst_start = op_seen & reset_armed & (op_word == `SFB_OP_RST) & ~rst_busy;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reset_armed <= 1'b0;
        end else if (low_s | rst_busy) begin
            reset_armed <= 1'b0;
        end else if (op_seen) begin
            reset_armed <= (op_word == `SFB_OP_RST_EN);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rst_busy <= 1'b0;
            rst_cnt <= '0;
        end else if (rst_start) begin
            rst_busy <= 1'b1;
            rst_cnt <= `SFB_RST_CNT_W'(RST_CYCLES - 1);
        end else if (rst_busy) begin
            rst_busy <= (rst_cnt != '0);
            rst_cnt <= rst_cnt - `SFB_RST_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= rst_start;
        end
    end
    assign reset_active = rst_busy;

    // ****************************************
    // Link side: synchronisers on the serial clock
    // ****************************************
    logic [1:0] qe_meta;
    logic [1:0] qe_sync;
    always_ff @(posedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            qe_meta <= 2'h0;
            qe_sync <= 2'h0;
        end else begin
            qe_meta <= {paused, quad_enable_bit};
            qe_sync <= qe_meta;
        end
    end
    wire qe_l = qe_sync[0];
    wire paused_l = qe_sync[1];

    // ****************************************
    // Link side: input shifting on rising edges
    // ****************************************
    sfb_phase_e ph;
    logic [4:0] cnt;
    logic [6:0] cmd_sh;
    logic [`SFB_ADDR_W-1:0] addr;
    logic [2:0] aw;
    logic [2:0] ow;
    logic [4:0] dclk;

    wire [7:0] op_full = {cmd_sh, lanes_in.lane_zero};
    wire [3:0] in_bits = take_bits(lanes_in, aw);
    wire [4:0] addr_clks = (aw == 3'h4) ? 5'h06 : ((aw == 3'h2) ? 5'h0C : 5'h18);
    wire op_dual_io = op_full == `SFB_OP_DUAL_IO;
    wire op_quad_io = op_full == `SFB_OP_QUAD_IO;
    wire op_read = (op_full == `SFB_OP_READ) || (op_full == `SFB_OP_FAST) ||
                   (op_full == `SFB_OP_DUAL_OUT) || op_dual_io || is_quad(op_full);
    wire op_ok = op_read & (~is_quad(op_full) | qe_l);
    wire [2:0] next_aw = op_quad_io ? 3'h4 : (op_dual_io ? 3'h2 : 3'h1);
    wire [2:0] next_ow = is_quad(op_full) ? 3'h4 :
                         ((op_full == `SFB_OP_DUAL_OUT) || op_dual_io) ? 3'h2 : 3'h1;
    wire [4:0] next_dclk = op_quad_io ? `SFB_DUMMY_QUAD_IO :
                           op_dual_io ? `SFB_DUMMY_DUAL_IO :
                           (op_full == `SFB_OP_READ) ? 5'h00 : `SFB_DUMMY_FAST;

    always_ff @(posedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            ph <= SFB_PH_CMD;
            cnt <= '0;
            cmd_sh <= '0;
            addr <= '0;
            aw <= 3'h1;
            ow <= 3'h1;
            dclk <= '0;
        end else if (!paused_l) begin
            cnt <= cnt + 5'h01;
            unique case (ph)
                SFB_PH_CMD: begin
                    cmd_sh <= op_full[6:0];
                    if (cnt == 5'h07) begin
                        cnt <= '0;
                        ph <= op_ok ? SFB_PH_ADDR : SFB_PH_IGNORE;
                        aw <= next_aw;
                        ow <= next_ow;
                        dclk <= next_dclk;
                    end
                end
                SFB_PH_ADDR: begin
                    addr <= `SFB_ADDR_W'((addr << aw) | `SFB_ADDR_W'(in_bits));
                    if (cnt == addr_clks - 5'h01) begin
                        cnt <= '0;
                        ph <= (dclk == '0) ? SFB_PH_DATA : SFB_PH_DUMMY;
                    end
                end
                SFB_PH_DUMMY: begin
                    if (cnt == dclk - 5'h01) begin
                        cnt <= '0;
                        ph <= SFB_PH_DATA;
                    end
                end
                SFB_PH_DATA, SFB_PH_IGNORE: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    // Opcode hand-off survives deselect, so only the system reset clears it
    always_ff @(posedge spi_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_tgl <= 1'b0;
            op_word <= 8'h00;
        end else if (!link_rst && !paused_l && ph == SFB_PH_CMD && cnt == 5'h07) begin
            op_tgl <= ~op_tgl;
            op_word <= op_full;
        end
    end

    // ****************************************
    // Link side: output shifting on falling edges
    // ****************************************
    logic [7:0] obyte;
    logic [2:0] ocnt;
    logic [`SFB_ADDR_W-1:0] rd_ptr;
    sfb_lanes_s out_q;
    sfb_lanes_s oe_q;
    logic started;

    // First byte reads the full address; the pointer takes over once output starts
    wire [`SFB_ADDR_W-1:0] ptr_cur = started ? rd_ptr : addr;
    wire [7:0] ob = (ocnt == 3'h0) ? rd_byte : obyte;
    wire [2:0] ocnt_last = (ow == 3'h4) ? 3'h1 : ((ow == 3'h2) ? 3'h3 : 3'h7);
    // lanes two and three carry data in quad
    wire sfb_lanes_s next_out = (ow == 3'h4) ? sfb_lanes_s'(ob[7:4]) :
                                (ow == 3'h2) ? sfb_lanes_s'({2'h0, ob[7:6]}) :
                                sfb_lanes_s'({2'h0, ob[7], 1'b0});
    wire sfb_lanes_s next_oe = (ow == 3'h4) ? sfb_lanes_s'(4'hF) :
                               (ow == 3'h2) ? sfb_lanes_s'(4'h3) : sfb_lanes_s'(4'h2);

    always_ff @(negedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            obyte <= '0;
            ocnt <= '0;
            rd_ptr <= '0;
            out_q <= '0;
            oe_q <= '0;
            started <= 1'b0;
        end else if (ph != SFB_PH_DATA) begin
            rd_ptr <= addr;
            ocnt <= '0;
            oe_q <= '0;
            started <= 1'b0;
        end else if (!paused_l) begin
            out_q <= next_out;
            oe_q <= next_oe;
            obyte <= 8'(ob << ow);
            ocnt <= (ocnt == ocnt_last) ? 3'h0 : ocnt + 3'h1;
            started <= 1'b1;
            rd_ptr <= (ocnt == ocnt_last) ? ptr_cur + `SFB_ADDR_W'(1) : ptr_cur;
        end
    end

    assign lanes_out = out_q;
    assign lanes_oe = sfb_lanes_s'(oe_q & {4{~paused}});
    assign rd_addr = ptr_cur & `SFB_TOP_ADDR;
    assign rd_region = region_of(ptr_cur);

    // ****************************************
    // Assertions
    // ****************************************
    a_quad_gate: assert property (@(posedge spi_clk) disable iff (link_rst)
        (ph == SFB_PH_CMD && cnt == 5'h07 && !paused_l && is_quad(op_full) && !qe_l)
        |=> ph == SFB_PH_IGNORE)
        else $error("quad instruction accepted without enable");

    a_pause_enter: assert property (@(posedge clock) disable iff (sys_rst)
        (pause_en && !cs_s && !sclk_s && !hold_s) |=> paused)
        else $error("pause not entered with clock low");

    a_pause_leave: assert property (@(posedge clock) disable iff (sys_rst)
        (paused && !cs_s && !sclk_s && hold_s) |=> !paused)
        else $error("pause not left with clock low");

    a_pause_defer: assert property (@(posedge clock) disable iff (sys_rst)
        (sclk_s && !cs_s) |=> $stable(paused))
        else $error("pause changed while clock high");

    a_pause_deselect: assert property (@(posedge clock) disable iff (sys_rst)
        cs_s |=> !paused ##1 !paused)
        else $error("pause survived deselect");

    a_pause_float: assert property (@(posedge clock) disable iff (sys_rst)
        paused |-> lanes_oe == 4'h0)
        else $error("lanes driven while paused");

    a_reset_pair: assert property (@(posedge clock) disable iff (sys_rst)
        (op_seen && reset_armed && op_word == `SFB_OP_RST && !rst_busy)
        |=> rst_busy && sw_reset ##1 !sw_reset)
        else $error("reset pair not honoured");

    a_reset_disarm: assert property (@(posedge clock) disable iff (sys_rst)
        (op_seen && op_word != `SFB_OP_RST_EN) |=> !reset_armed)
        else $error("reset stayed armed");

    a_reset_reject: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(rst_busy) |-> quiet [*8])
        else $error("instructions not rejected during reset");

    a_first_select: assert property (@(posedge clock) disable iff (sys_rst)
        !sel_armed |-> link_rst)
        else $error("selected before first high");

    a_standby_busy: assert property (@(posedge clock) disable iff (sys_rst)
        (busy_in && cs_s) |=> !standby)
        else $error("standby while busy");

endmodule

// File: verilog/sfb_pkg.sv
package sfb_pkg;

    typedef enum logic [2:0] {
        SFB_PH_CMD,
        SFB_PH_ADDR,
        SFB_PH_DUMMY,
        SFB_PH_DATA,
        SFB_PH_IGNORE
    } sfb_phase_e;

    typedef struct packed {
        logic lane_three;
        logic lane_two;
        logic lane_one;
        logic lane_zero;
    } sfb_lanes_s;

    typedef struct packed {
        logic [5:0] sector;
        logic [2:0] half;
        logic [1:0] block;
    } sfb_region_s;

endpackage
